// *** fcp_decode.v ***
// configuration decode: drive strength, pin role, wait cycles and array protection
// Behaviour
// (R1) output_strength picks full, 3/4, 1/2, 1/4 drive
// (R2) pin select 0 pause, 1 active-low reset
// (R3) four_lane_enable makes pin a data lane only
// (R4) single/dual/quad output fast reads wait 8
// (R5) dual-I/O and quad word read: 4 or 8
// (R6) quad-I/O fast read waits 6,4,8,10
// (R7) reserved bits: writes ignored, read zero
// (R8) host ignores reserved bit values
// (R9) level 0 none, 7 all, 128KB..4MB steps
// (R10) sector granule: 4K,8K,16K,32K at chosen end
// (R11) erase/program touching protected area is ignored
// (R12) guard_invert protects the complement region
// (R13) decode follows stored bits, next command onward
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fcp_regs.vh"

module fcp_decode (
    input  wire        clk,               // 50 MHz clock
    input  wire        reset_n,           // synchronous reset, active low
    input  wire [3:0]  avs_address,       // byte address
    input  wire        avs_read,          // read request
    input  wire        avs_write,         // write request
    input  wire [3:0]  avs_byteenable,    // byte lanes
    input  wire [31:0] avs_writedata,     // write data
    output reg  [31:0] avs_readdata,      // read data
    output reg         avs_waitrequest,   // stall
    input  wire        mp_pin_in,         // multipurpose pin level
    input  wire        op_valid,          // erase/program request pulse
    input  wire [22:0] op_first,          // first target byte
    input  wire [22:0] op_last,           // last target byte
    output reg         op_go_ff,          // request accepted pulse
    output reg         op_blocked_ff,     // request ignored pulse
    output reg  [1:0]  drive_code_ff,     // output_strength field
    output reg  [6:0]  drive_pct_ff,      // drive strength in percent
    output reg         pause_active_ff,   // pause asserted by pin
    output reg         pin_reset_ff,      // reset asserted by pin
    output reg         data_lane_ff,      // pin is a data lane
    output reg  [3:0]  wait_out_ff,       // wait cycles, output-only fast reads
    output reg  [3:0]  wait_dual_io_ff,   // wait cycles, dual-I/O and quad word read
    output reg  [3:0]  wait_quad_io_ff,   // wait cycles, quad-I/O fast read
    output reg         prot_any_ff,       // something is protected
    output reg  [22:0] prot_lo_ff,        // protected range start
    output reg  [22:0] prot_hi_ff         // protected range end
);
    reg  [`FCP_CFG_WIDTH-1:0] config_ff;
    reg  [`FCP_CFG_WIDTH-1:0] nxt_config;
    reg  [6:0]  nxt_drive_pct;
    reg  [3:0]  nxt_wait_dual;
    reg  [3:0]  nxt_wait_quad;
    reg  [31:0] nxt_readdata;
    reg         nxt_pause;
    reg         nxt_reset;
    reg         nxt_lane;
    wire        dec_any;
    wire [22:0] dec_lo;
    wire [22:0] dec_hi;
    wire        req;
    wire        hit;

    wire [1:0] output_strength   = config_ff[`FCP_CFG_STRENGTH_HI:`FCP_CFG_STRENGTH_LO];
    wire       pin_select        = config_ff[`FCP_CFG_PIN_SELECT];
    wire       four_lane_enable  = config_ff[`FCP_CFG_FOUR_LANE];
    wire [1:0] wait_cycle_select = config_ff[`FCP_CFG_WAIT_HI:`FCP_CFG_WAIT_LO];

    assign req = avs_read | avs_write;

    // protection range follows the stored bits without delay
    fcp_range u_range (
        .guard_level    (config_ff[`FCP_CFG_LEVEL_HI:`FCP_CFG_LEVEL_LO]),
        .granule_select (config_ff[`FCP_CFG_GRANULE]),
        .from_low_end   (config_ff[`FCP_CFG_LOW_END]),
        .guard_invert   (config_ff[`FCP_CFG_INVERT]),
        .prot_any       (dec_any),
        .prot_lo        (dec_lo),
        .prot_hi        (dec_hi)
    );

    // any overlap with the protected window blocks the whole operation
    assign hit = dec_any && (op_first <= dec_hi) && (op_last >= dec_lo); // R11

    // config write: only when the master sees waitrequest low; bits 15:12 are reserved
    always @* begin
        nxt_config = config_ff;
        if (avs_write && !avs_waitrequest && avs_address == `FCP_ADDR_CONFIG) begin
            if (avs_byteenable[0])
                nxt_config[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1])
                nxt_config[`FCP_CFG_WIDTH-1:8] = avs_writedata[`FCP_CFG_WIDTH-1:8]; // R7
        end
    end

    // drive strength, pin role and wait-cycle decode
    always @* begin
        case (output_strength)
            2'h0:    nxt_drive_pct = `FCP_DRIVE_FULL;     // R1
            2'h1:    nxt_drive_pct = `FCP_DRIVE_THREE_Q;  // R1
            2'h2:    nxt_drive_pct = `FCP_DRIVE_HALF;     // R1
            default: nxt_drive_pct = `FCP_DRIVE_QUARTER;  // R1
        endcase
        // four lanes take the pin away from both pause and reset
        nxt_lane  = four_lane_enable;                                 // R3
        nxt_pause = !four_lane_enable && !pin_select && !mp_pin_in;   // R2 R3
        nxt_reset = !four_lane_enable && pin_select && !mp_pin_in;    // R2 R3
        nxt_wait_dual = wait_cycle_select[0] ? `FCP_WAIT_8 : `FCP_WAIT_4; // R5
        case (wait_cycle_select)
            2'h0:    nxt_wait_quad = `FCP_WAIT_6;   // R6
            2'h1:    nxt_wait_quad = `FCP_WAIT_4;   // R6
            2'h2:    nxt_wait_quad = `FCP_WAIT_8;   // R6
            default: nxt_wait_quad = `FCP_WAIT_10;  // R6
        endcase
    end

    // read mux; reserved and unmapped bits read as zero
    always @* begin
        case (avs_address)
            `FCP_ADDR_CONFIG:  nxt_readdata = {20'h00000, config_ff};  // R7
            `FCP_ADDR_DECODE:  nxt_readdata = {8'h00, data_lane_ff, pin_reset_ff, pause_active_ff,
                                               wait_quad_io_ff, wait_dual_io_ff, wait_out_ff,
                                               drive_pct_ff, drive_code_ff};
            `FCP_ADDR_PROT_LO: nxt_readdata = {9'h000, prot_lo_ff};
            `FCP_ADDR_PROT_HI: nxt_readdata = {prot_any_ff, 8'h00, prot_hi_ff};
            default:           nxt_readdata = 32'h00000000;
        endcase
    end

    // bus slave: one wait cycle, then waitrequest low for exactly one cycle
    always @(posedge clk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (req && avs_waitrequest)
                avs_readdata <= nxt_readdata;
        end
    end

    // stored bits and registered decode; a setting acts from the next cycle on
    always @(posedge clk) begin
        if (!reset_n) begin
            config_ff       <= `FCP_CFG_RESET;
            op_go_ff        <= 1'b0;
            op_blocked_ff   <= 1'b0;
            drive_code_ff   <= 2'h0;
            drive_pct_ff    <= 7'h00;
            pause_active_ff <= 1'b0;
            pin_reset_ff    <= 1'b0;
            data_lane_ff    <= 1'b0;
            wait_out_ff     <= 4'h0;
            wait_dual_io_ff <= 4'h0;
            wait_quad_io_ff <= 4'h0;
            prot_any_ff     <= 1'b0;
            prot_lo_ff      <= 23'h000000;
            prot_hi_ff      <= 23'h000000;
        end else begin
            config_ff       <= nxt_config;
            op_go_ff        <= op_valid && !hit;   // R11 R13
            op_blocked_ff   <= op_valid && hit;    // R11
            drive_code_ff   <= output_strength;
            drive_pct_ff    <= nxt_drive_pct;      // R1
            pause_active_ff <= nxt_pause;
            pin_reset_ff    <= nxt_reset;
            data_lane_ff    <= nxt_lane;
            wait_out_ff     <= `FCP_WAIT_8;        // R4
            wait_dual_io_ff <= nxt_wait_dual;
            wait_quad_io_ff <= nxt_wait_quad;
            prot_any_ff     <= dec_any;            // R13
            prot_lo_ff      <= dec_lo;
            prot_hi_ff      <= dec_hi;
        end
    end
endmodule
`default_nettype wire

// *** fcp_regs.vh ***
// register map, field positions, reset values and decode constants for the config decode block
`ifndef FCP_REGS_VH
`define FCP_REGS_VH

`define FCP_ADDR_CONFIG   4'h0
`define FCP_ADDR_DECODE   4'h4
`define FCP_ADDR_PROT_LO  4'h8
`define FCP_ADDR_PROT_HI  4'hc

`define FCP_CFG_STRENGTH_LO   0
`define FCP_CFG_STRENGTH_HI   1
`define FCP_CFG_PIN_SELECT    2
`define FCP_CFG_FOUR_LANE     3
`define FCP_CFG_WAIT_LO       4
`define FCP_CFG_WAIT_HI       5
`define FCP_CFG_GRANULE       6
`define FCP_CFG_LOW_END       7
`define FCP_CFG_LEVEL_LO      8
`define FCP_CFG_LEVEL_HI      10
`define FCP_CFG_INVERT        11
`define FCP_CFG_WIDTH         12
`define FCP_CFG_RESET         12'h001

`define FCP_DRIVE_FULL        7'h64
`define FCP_DRIVE_THREE_Q     7'h4b
`define FCP_DRIVE_HALF        7'h32
`define FCP_DRIVE_QUARTER     7'h19

`define FCP_WAIT_4            4'h4
`define FCP_WAIT_6            4'h6
`define FCP_WAIT_8            4'h8
`define FCP_WAIT_10           4'ha

`define FCP_ARRAY_BYTES       24'h800000
`define FCP_BLOCK_PAIR_BYTES  24'h020000
`define FCP_SECTOR_BYTES      24'h001000
`define FCP_SECTOR_MAX_BYTES  24'h008000
`define FCP_LEVEL_NONE        3'h0
`define FCP_LEVEL_ALL         3'h7

`endif

// *** fcp_range.v ***
// protected address range decode from granule, direction, level and invert bits
`timescale 1ns/1ns
`default_nettype none
`include "fcp_regs.vh"

module fcp_range (
    input  wire [2:0]  guard_level,     // three level bits
    input  wire        granule_select,  // 1 = 4KB steps, 0 = 128KB steps
    input  wire        from_low_end,    // 1 = bottom of array
    input  wire        guard_invert,    // protect the complement
    output reg         prot_any,        // some part is protected
    output reg  [22:0] prot_lo,         // first protected byte
    output reg  [22:0] prot_hi          // last protected byte
);
    reg [23:0] size;
    reg        all;
    reg        none;
    reg [23:0] rest;

    // size of the region before inversion
    always @* begin
        size = 24'h000000;
        none = (guard_level == `FCP_LEVEL_NONE);
        all  = (guard_level == `FCP_LEVEL_ALL);
        if (!none && !all) begin
            if (granule_select) begin
                case (guard_level)
                    3'h1:    size = `FCP_SECTOR_BYTES;             // R10
                    3'h2:    size = `FCP_SECTOR_BYTES << 1;        // R10
                    3'h3:    size = `FCP_SECTOR_BYTES << 2;        // R10
                    default: size = `FCP_SECTOR_MAX_BYTES;         // R10
                endcase
            end else begin
                size = `FCP_BLOCK_PAIR_BYTES << (guard_level - 3'h1); // R9
            end
        end
        rest = `FCP_ARRAY_BYTES - size;
    end

    // the complement of a top region is the bottom remainder, so it stays contiguous
    always @* begin
        prot_any = 1'b0;
        prot_lo  = 23'h000000;
        prot_hi  = 23'h7fffff;
        if (all) begin
            prot_any = !guard_invert;                                // R9 R12
        end else if (none) begin
            prot_any = guard_invert;                                 // R9 R12
        end else begin
            prot_any = 1'b1;
            if (from_low_end ^ guard_invert) begin
                prot_lo = 23'h000000;
                prot_hi = guard_invert ? rest[22:0] - 23'h1 : size[22:0] - 23'h1; // R12
            end else begin
                prot_lo = guard_invert ? size[22:0] : rest[22:0];     // R12
                prot_hi = 23'h7fffff;
            end
        end
    end
endmodule
`default_nettype wire

// *** fcp_decode_asserts.sv ***
// checker on the decode outputs
`timescale 1ns/1ns
`default_nettype none
module fcp_decode_asserts (
    input wire logic        clk,             // clock
    input wire logic        reset_n,         // sync reset
    input wire logic        op_valid,        // op pulse
    input wire logic        op_go_ff,        // accepted
    input wire logic        op_blocked_ff,   // ignored
    input wire logic [1:0]  drive_code_ff,   // strength
    input wire logic [6:0]  drive_pct_ff,    // percent
    input wire logic        pause_active_ff, // pause
    input wire logic        pin_reset_ff,    // pin reset
    input wire logic        data_lane_ff,    // data lane
    input wire logic [3:0]  wait_out_ff,     // out reads
    input wire logic [3:0]  wait_dual_io_ff, // dual io
    input wire logic [3:0]  wait_quad_io_ff, // quad io
    input wire logic [22:0] prot_lo_ff,      // start
    input wire logic [22:0] prot_hi_ff       // end
);
    default clocking dck @(posedge clk); endclocking
    default disable iff (!reset_n);
    // every op gets exactly one verdict one cycle later
    sequence op_req; op_valid; endsequence
    sequence op_ans; op_go_ff ^ op_blocked_ff; endsequence
    op_answer_a: assert property (op_req |=> op_ans)
        else $error("op verdict missing");
    op_quiet_a: assert property (!op_valid |=> !op_go_ff && !op_blocked_ff)
        else $error("verdict without op");
    // decode outputs lag reset release by one edge
    out_wait_a: assert property ($past(reset_n) |-> wait_out_ff == 4'h8)
        else $error("output read wait wrong");
    dual_wait_a: assert property ($past(reset_n) |-> wait_dual_io_ff inside {4'h4, 4'h8})
        else $error("dual io wait wrong");
    quad_wait_a: assert property ($past(reset_n) |-> wait_quad_io_ff inside {4'h4, 4'h6, 4'h8, 4'ha})
        else $error("quad io wait wrong");
    drive_map_a: assert property ($past(reset_n) |-> drive_pct_ff == (drive_code_ff[1] ?
        (drive_code_ff[0] ? 7'h19 : 7'h32) : (drive_code_ff[0] ? 7'h4b : 7'h64)))
        else $error("drive percent wrong");
    lane_only_a: assert property (data_lane_ff |-> !pause_active_ff && !pin_reset_ff)
        else $error("lane with pin role");
    pin_role_a: assert property (pin_reset_ff |-> !pause_active_ff)
        else $error("two pin roles");
    prot_order_a: assert property (prot_lo_ff <= prot_hi_ff)
        else $error("range reversed");
endmodule
`default_nettype wire

// *** fcp_host_model.sv ***
// far-side host: pin level and erase/program requests
`timescale 1ns/1ns
`default_nettype none
module fcp_host_model (
    input  wire logic        clk,       // clock
    output var  logic        mp_pin_in, // pin level
    output var  logic        op_valid,  // op pulse
    output var  logic [22:0] op_first,  // first byte
    output var  logic [22:0] op_last    // last byte
);
    // pin pulled high; range lines carry junk outside a request
    initial begin
        mp_pin_in = 1'b1;
        op_valid = 1'b0;
        op_first = 23'h5a5a5a;
        op_last = 23'h25a5a5;
    end
    task automatic set_pin(input logic lvl);
        @(posedge clk);
        mp_pin_in <= lvl;
    endtask
    // stale range is inverted so it never passes for a live one
    task automatic op(input logic [22:0] f, input logic [22:0] l);
        @(posedge clk);
        op_valid <= 1'b1;
        op_first <= f;
        op_last <= l;
        @(posedge clk);
        op_valid <= 1'b0;
        op_first <= ~f;
        op_last <= ~l;
    endtask
endmodule
`default_nettype wire

// *** tb_flash_config_protect_decode.sv ***
// testbench for the config decode block
`timescale 1ns/1ns
`default_nettype none
module tb_flash_config_protect_decode;
    logic             clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0]       addr = 4'h0;
    logic [31:0]      wdata = 32'h0, q;
    wire logic [31:0] rdata;
    wire logic        wreq, go, blk, pin, opv;
    wire logic [22:0] op_f, op_l;
    int               err_count = 0, comparisons = 0;
    logic [11:0] pc [10] = '{12'h101, 12'h681, 12'h001, 12'h701, 12'h141, 12'h3c1, 12'h541, 12'h6c1, 12'h901, 12'h441};
    logic [22:0] pl [10] = '{23'h7e0000, 0, 0, 0, 23'h7ff000, 0, 23'h7f8000, 0, 0, 23'h7f8000};
    logic [31:0] ph [10] = '{32'h807fffff, 32'h803fffff, 32'h007fffff, 32'h807fffff, 32'h807fffff,
                             32'h80003fff, 32'h807fffff, 32'h80007fff, 32'h807dffff, 32'h807fffff};
    always #10 clk = ~clk;
    fcp_host_model host (.clk(clk), .mp_pin_in(pin), .op_valid(opv), .op_first(op_f), .op_last(op_l));
    fcp_decode DUT (.clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_byteenable(4'hf), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .mp_pin_in(pin), .op_valid(opv), .op_first(op_f), .op_last(op_l), .op_go_ff(go), .op_blocked_ff(blk),
        .drive_code_ff(), .drive_pct_ff(), .pause_active_ff(), .pin_reset_ff(), .data_lane_ff(),
        .wait_out_ff(), .wait_dual_io_ff(), .wait_quad_io_ff(), .prot_any_ff(), .prot_lo_ff(), .prot_hi_ff());
    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, wreq, 1'b0);
            final_report();
        end
    endtask
    // expected decode word: pin bits are {lane, reset, pause}
    function automatic logic [31:0] dec(input logic [1:0] s, input logic [1:0] w, input logic [2:0] p);
        logic [6:0] pct;
        logic [3:0] qd;
        pct = s == 0 ? 7'h64 : s == 1 ? 7'h4b : s == 2 ? 7'h32 : 7'h19;
        qd = w == 0 ? 4'h6 : w == 1 ? 4'h4 : w == 2 ? 4'h8 : 4'ha;
        return {8'h0, p, qd, w[0] ? 4'h8 : 4'h4, 4'h8, pct, s};
    endfunction
    task automatic opchk(input logic [31:0] c, input logic [22:0] f, input logic [22:0] l, input logic [1:0] e);
        bus(1'b1, 4'h0, c);
        host.op(f, l);
        @(posedge clk);
        chk({30'h0, go, blk}, {30'h0, e});
    endtask
    initial begin
        int i;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, 4'h0, 0); chk(q & 32'h0fff, 32'h001);
        bus(1'b0, 4'h4, 0); chk(q, dec(1, 0, 0));
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 4'h0, (i << 4) | i);
            bus(1'b0, 4'h4, 0); chk(q, dec(i[1:0], i[1:0], 0));
        end
        host.set_pin(1'b0);
        for (i = 0; i < 3; i++) begin
            bus(1'b1, 4'h0, i == 2 ? 32'h8 : i << 2);
            bus(1'b0, 4'h4, 0); chk(q, dec(0, 0, 3'h1 << i));
        end
        host.set_pin(1'b1);
        bus(1'b1, 4'h0, 32'hffff_f0a1);
        bus(1'b0, 4'h0, 0); chk(q & 32'h0fff, 32'h0a1);
        bus(1'b0, 4'h4, 0); chk(q, dec(1, 2, 0));
        bus(1'b0, 4'h2, 0); chk(q, 0);
        for (i = 0; i < 10; i++) begin
            bus(1'b1, 4'h0, pc[i]);
            bus(1'b0, 4'h8, 0); chk(q, {9'h0, pl[i]});
            bus(1'b0, 4'hc, 0); chk(q, ph[i]);
        end
        opchk(32'h101, 23'h0, 23'h000fff, 2'b10);
        opchk(32'h101, 23'h7d0000, 23'h7e0000, 2'b01);
        opchk(32'h001, 23'h7fffff, 23'h7fffff, 2'b10);
        opchk(32'h901, 23'h7e0000, 23'h7fffff, 2'b10);
        opchk(32'h3c1, 23'h003fff, 23'h004000, 2'b01);
        final_report();
    end
endmodule
bind fcp_decode fcp_decode_asserts u_chk (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_go_ff(op_go_ff),
    .op_blocked_ff(op_blocked_ff), .drive_code_ff(drive_code_ff), .drive_pct_ff(drive_pct_ff),
    .pause_active_ff(pause_active_ff), .pin_reset_ff(pin_reset_ff), .data_lane_ff(data_lane_ff),
    .wait_out_ff(wait_out_ff), .wait_dual_io_ff(wait_dual_io_ff), .wait_quad_io_ff(wait_quad_io_ff),
    .prot_lo_ff(prot_lo_ff), .prot_hi_ff(prot_hi_ff));
`default_nettype wire
